// >>> src/flc_pkg.sv
// Register map, field layout, reset values and timing constants of the loop control block
package flc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h070;
  localparam logic [9:0] IDX_DIV = 10'h071;
  localparam logic [9:0] IDX_FRAC = 10'h072;
  localparam logic [9:0] IDX_INT = 10'h073;
  localparam logic [9:0] IDX_REF = 10'h074;
  localparam logic [9:0] IDX_ROUTE = 10'h075;
  localparam logic [9:0] IDX_STAT = 10'h076;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h077;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h078;
  localparam logic [9:0] IDX_FRC_SEL = 10'h0F7;
  localparam logic [9:0] IDX_FRC_VAL = 10'h0F8;
  // Field positions
  localparam int CTRL_OSC_EN = 0;
  localparam int CTRL_FRAC_EN = 1;
  localparam int CTRL_SYS_SEL = 2;
  localparam int DIV_RATIO_LSB = 0;
  localparam int DIV_RATE_LSB = 4;
  localparam int DIV_OUTDIV_LSB = 8;
  localparam int FRAC_K_LSB = 0;
  localparam int INT_GAIN_LSB = 0;
  localparam int INT_N_LSB = 5;
  localparam int REF_DIV_LSB = 3;
  localparam int ROUTE_SEL_LSB = 0;
  localparam int ROUTE_OE = 2;
  localparam int FRC_SEL_BIT = 0;
  localparam int FRC_VAL_LSB = 0;
  // Reset values
  localparam logic [5:0] OUTDIV_RST = 6'h07;
  localparam logic [2:0] RATIO_RST = 3'h7;
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [15:0] FRAC_K_RST = 16'h0000;
  localparam logic [9:0] INT_N_RST = 10'h177;
  localparam logic [3:0] GAIN_RST = 4'h0;
  localparam logic [1:0] REFDIV_RST = 2'h0;
  localparam logic [5:0] FRC_VAL_RST = 6'h19;
  localparam logic [15:0] CTRL_WORD_RST = 16'h6400;
  // Gpio route codes
  localparam logic [1:0] ROUTE_LOW = 2'h0;
  localparam logic [1:0] ROUTE_LOCK = 2'h1;
  localparam logic [1:0] ROUTE_CLK = 2'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_TIMEOUT_NS = 100000;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LOCK_LAST = 3'h3;
endpackage : flc_pkg

// >>> src/flc_freerun_ctrl.sv
// Loop clock control: registers, digital oscillator model, lock detect, gpio routing and interrupt
`timescale 1ns/100ps
module flc_freerun_ctrl
  import flc_pkg::*;
#(
  parameter int REF_TMO_CYC = REF_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reference pin and loop outputs
  input wire logic ref_clk_in,
  output logic loop_clk_out,
  output logic loop_lock,
  output logic system_clock_source_select,
  // Gpio pin driven from the loop
  output logic loop_gpio_out,
  output logic loop_gpio_oe,
  // Interrupt
  output logic irq
);

  // Timeout counter is 20 bits wide
  if (REF_TMO_CYC < 2 || REF_TMO_CYC > 1048575) begin : g_chk
    $error("REF_TMO_CYC out of range");
  end

  localparam logic [19:0] TMO_LAST = 20'(REF_TMO_CYC - 1);

  // Whole state of the block
  typedef struct packed {
    logic aw_hold;          // Write address taken, waiting for data
    logic [9:0] aw_idx;
    logic w_hold;           // Write data taken, waiting for address
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic osc_en;           // Analogue oscillator enable
    logic frac_en;          // Fractional mode enable
    logic sys_sel;          // System clock source select
    logic [5:0] outdiv;
    logic [2:0] ctrl_rate;  // Stored only; the model updates once per measurement
    logic [2:0] ratio;
    logic [15:0] frac_k;
    logic [9:0] int_n;
    logic [3:0] gain;
    logic [1:0] refdiv;
    logic [2:0] route;
    logic frc_sel;
    logic [5:0] frc_val;
    logic [1:0] irq_stat;   // Bit 0 lock gained, bit 1 lock lost
    logic [1:0] irq_mask;
    logic irq;
    logic ref_s1;           // Synchroniser stage one
    logic ref_s2;
    logic ref_s3;           // Edge detect delay
    logic [15:0] acc;       // Oscillator phase accumulator
    logic [15:0] ctrl_word; // Loop-controlled increment
    logic [4:0] pre_cnt;    // Reference ratio prescaler
    logic [15:0] fb_cnt;    // Divided oscillator ticks per reference window
    logic [2:0] refe_cnt;   // Reference edges in current window
    logic [2:0] lock_cnt;
    logic lock;
    logic ref_lost;
    logic [19:0] tmo_cnt;
    logic [6:0] od_cnt;     // Output divider counter
    logic loop_clk;
    logic gpio_out;
    logic gpio_oe;
  } flc_state_s;

  flc_state_s q_ff;
  flc_state_s nxt_q;

  // Read value of one register
  function automatic logic [31:0] reg_value(input flc_state_s s, input logic [9:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      IDX_CTRL: begin
        v[CTRL_OSC_EN] = s.osc_en;
        v[CTRL_FRAC_EN] = s.frac_en;
        v[CTRL_SYS_SEL] = s.sys_sel;
      end
      IDX_DIV: begin
        v[DIV_RATIO_LSB +: 3] = s.ratio;
        v[DIV_RATE_LSB +: 3] = s.ctrl_rate;
        v[DIV_OUTDIV_LSB +: 6] = s.outdiv;
      end
      IDX_FRAC: v[FRAC_K_LSB +: 16] = s.frac_k;
      IDX_INT: begin
        v[INT_GAIN_LSB +: 4] = s.gain;
        v[INT_N_LSB +: 10] = s.int_n;
      end
      IDX_REF: v[REF_DIV_LSB +: 2] = s.refdiv;
      IDX_ROUTE: v[2:0] = s.route;
      IDX_STAT: v[2:0] = {s.frc_sel, s.ref_lost, s.lock};
      IDX_IRQ_STAT: v[1:0] = s.irq_stat;
      IDX_IRQ_MASK: v[1:0] = s.irq_mask;
      IDX_FRC_SEL: v[FRC_SEL_BIT] = s.frc_sel;
      IDX_FRC_VAL: v[FRC_VAL_LSB +: 6] = s.frc_val;
      default: v = 32'h0000_0000;                // Unmapped reads as zero
    endcase
    return v;
  endfunction : reg_value

  // Address decode
  function automatic logic is_mapped(input logic [9:0] idx);
    return idx inside {IDX_CTRL, IDX_DIV, IDX_FRAC, IDX_INT, IDX_REF, IDX_ROUTE, IDX_STAT,
                       IDX_IRQ_STAT, IDX_IRQ_MASK, IDX_FRC_SEL, IDX_FRC_VAL};
  endfunction : is_mapped

  // Next-state logic
  always_comb begin
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [31:0] bmask;
    logic [31:0] m;
    logic [15:0] vco_inc;
    logic [16:0] sum;
    logic tick;
    logic fb_tick;          // Divided tick that lands in the feedback count
    logic [4:0] ratio_div;
    logic [6:0] od_div;
    logic ref_edge;
    logic [15:0] target;
    logic [15:0] step;
    logic [16:0] up;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    aw_take = 1'b0;
    w_take = 1'b0;
    ar_take = 1'b0;
    bmask = 32'h0000_0000;
    m = 32'h0000_0000;
    target = 16'h0000;
    step = 16'h0000;
    up = 17'h0_0000;
    irq_clr = 2'h0;
    fb_tick = 1'b0;
    nxt_q = q_ff;

    // Reference synchroniser; stage one feeds only stage two
    nxt_q.ref_s1 = ref_clk_in;
    nxt_q.ref_s2 = q_ff.ref_s1;
    nxt_q.ref_s3 = q_ff.ref_s2;
    ref_edge = q_ff.ref_s2 & ~q_ff.ref_s3;

    // Oscillator: forced value replaces the loop word when selected
    vco_inc = q_ff.frc_sel ? {q_ff.frc_val, 10'h000} : q_ff.ctrl_word;
    sum = {1'b0, q_ff.acc} + {1'b0, vco_inc};
    tick = q_ff.osc_en & sum[16];
    if (q_ff.osc_en) begin
      nxt_q.acc = sum[15:0];
    end

    // Reference ratio: 1,2,4,8, or 16 for any code 1XX
    ratio_div = q_ff.ratio[2] ? 5'h10 : 5'(5'h01 << q_ff.ratio[1:0]);
    // Divider codes below 3 are reserved and act as divide by four
    od_div = (q_ff.outdiv < 6'h03) ? 7'h04 : {1'b0, q_ff.outdiv} + 7'h01;
    // A tick in the window-edge cycle opens the new window, so no tick is lost
    fb_tick = tick & (q_ff.pre_cnt == ratio_div - 5'h01);

    // Per oscillator tick: prescaler, feedback count, output divider
    if (tick) begin
      if (q_ff.pre_cnt == ratio_div - 5'h01) begin
        nxt_q.pre_cnt = 5'h00;
        if (q_ff.fb_cnt != 16'hFFFF) begin
          nxt_q.fb_cnt = q_ff.fb_cnt + 16'h0001;
        end
      end else begin
        nxt_q.pre_cnt = q_ff.pre_cnt + 5'h01;
      end
      if (q_ff.od_cnt >= od_div - 7'h01) begin
        nxt_q.od_cnt = 7'h00;
      end else begin
        nxt_q.od_cnt = q_ff.od_cnt + 7'h01;
      end
      nxt_q.loop_clk = nxt_q.od_cnt < (od_div >> 1);
    end

    // Frequency measurement and loop word update, once per reference window
    if (ref_edge) begin
      nxt_q.tmo_cnt = 20'h0_0000;
      nxt_q.ref_lost = 1'b0;
      if (q_ff.ref_lost) begin
        // First edge after a loss only restarts the window
        nxt_q.refe_cnt = 3'h0;
        nxt_q.fb_cnt = {15'h0000, fb_tick};
        nxt_q.pre_cnt = 5'h00;
      end else if (q_ff.refe_cnt == 3'(({1'b0, 3'h1} << q_ff.refdiv) - 4'h1)) begin
        nxt_q.refe_cnt = 3'h0;
        nxt_q.fb_cnt = {15'h0000, fb_tick};
        if (q_ff.osc_en && !q_ff.frc_sel) begin
          // Fraction of one half or more rounds the integer target up
          target = {6'h00, q_ff.int_n} + {15'h0000, q_ff.frac_en & q_ff.frac_k[15]};
          step = 16'h0001 << ((q_ff.gain > 4'h8) ? 4'h8 : q_ff.gain);
          if (q_ff.fb_cnt == target) begin
            if (q_ff.lock_cnt == LOCK_LAST) begin
              nxt_q.lock = 1'b1;
            end else begin
              nxt_q.lock_cnt = q_ff.lock_cnt + 3'h1;
            end
          end else begin
            nxt_q.lock_cnt = 3'h0;
            nxt_q.lock = 1'b0;
            if (q_ff.fb_cnt < target) begin
              up = {1'b0, q_ff.ctrl_word} + {1'b0, step};
              nxt_q.ctrl_word = up[16] ? 16'hFFFF : up[15:0];
            end else begin
              nxt_q.ctrl_word = (q_ff.ctrl_word < step) ? 16'h0000 : q_ff.ctrl_word - step;
            end
          end
        end
      end else begin
        nxt_q.refe_cnt = q_ff.refe_cnt + 3'h1;
      end
    end else if (!q_ff.ref_lost) begin
      // Missing reference: freeze the loop word so the output stays stable
      if (q_ff.tmo_cnt == TMO_LAST) begin
        nxt_q.ref_lost = 1'b1;
      end else begin
        nxt_q.tmo_cnt = q_ff.tmo_cnt + 20'h0_0001;
      end
    end

    // No lock without a running, loop-controlled oscillator
    if (!q_ff.osc_en || q_ff.frc_sel) begin
      nxt_q.lock = 1'b0;
      nxt_q.lock_cnt = 3'h0;
    end

    // Gpio routing of lock or loop clock, independent of system clock choice
    nxt_q.gpio_oe = q_ff.route[ROUTE_OE];
    unique case (q_ff.route[ROUTE_SEL_LSB +: 2])
      ROUTE_LOCK: nxt_q.gpio_out = q_ff.lock;
      ROUTE_CLK: nxt_q.gpio_out = q_ff.loop_clk;
      default: nxt_q.gpio_out = 1'b0;
    endcase

    // Bus: address and data channels taken independently
    aw_take = s_axi_awvalid & q_ff.awready;
    w_take = s_axi_wvalid & q_ff.wready;
    if (aw_take) begin
      nxt_q.aw_hold = 1'b1;
      nxt_q.aw_idx = s_axi_awaddr[11:2];
    end
    if (w_take) begin
      nxt_q.w_hold = 1'b1;
      nxt_q.w_data = s_axi_wdata;
      nxt_q.w_strb = s_axi_wstrb;
    end
    if (q_ff.bvalid && s_axi_bready) begin
      nxt_q.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (nxt_q.aw_hold && nxt_q.w_hold && !q_ff.bvalid) begin
      for (int b = 0; b < 4; b++) begin
        bmask[8 * b +: 8] = {8{nxt_q.w_strb[b]}};
      end
      m = (reg_value(q_ff, nxt_q.aw_idx) & ~bmask) | (nxt_q.w_data & bmask);
      unique case (nxt_q.aw_idx)
        IDX_CTRL: begin
          nxt_q.osc_en = m[CTRL_OSC_EN];
          nxt_q.frac_en = m[CTRL_FRAC_EN];
          nxt_q.sys_sel = m[CTRL_SYS_SEL];
        end
        IDX_DIV: begin
          nxt_q.ratio = m[DIV_RATIO_LSB +: 3];
          nxt_q.ctrl_rate = m[DIV_RATE_LSB +: 3];
          nxt_q.outdiv = m[DIV_OUTDIV_LSB +: 6];
        end
        IDX_FRAC: nxt_q.frac_k = m[FRAC_K_LSB +: 16];
        IDX_INT: begin
          nxt_q.gain = m[INT_GAIN_LSB +: 4];
          nxt_q.int_n = m[INT_N_LSB +: 10];
        end
        IDX_REF: nxt_q.refdiv = m[REF_DIV_LSB +: 2];
        IDX_ROUTE: nxt_q.route = m[2:0];
        IDX_IRQ_MASK: nxt_q.irq_mask = m[1:0];
        IDX_FRC_SEL: nxt_q.frc_sel = m[FRC_SEL_BIT];
        IDX_FRC_VAL: nxt_q.frc_val = m[FRC_VAL_LSB +: 6];
        default: ;                                     // Read-only or unmapped: no effect
      endcase
      nxt_q.aw_hold = 1'b0;
      nxt_q.w_hold = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = is_mapped(nxt_q.aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    // Readiness registered so the ports come straight from flops
    nxt_q.awready = !nxt_q.aw_hold && !nxt_q.bvalid;
    nxt_q.wready = !nxt_q.w_hold && !nxt_q.bvalid;

    // Bus read; reading the interrupt status clears it
    ar_take = s_axi_arvalid & q_ff.arready;
    if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = reg_value(q_ff, s_axi_araddr[11:2]);
      nxt_q.rresp = is_mapped(s_axi_araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr[11:2] == IDX_IRQ_STAT) begin
        irq_clr = 2'h3;
      end
    end
    nxt_q.arready = !nxt_q.rvalid;

    // Lock events are sticky; a new event beats a clearing read
    irq_set = {q_ff.lock & ~nxt_q.lock, nxt_q.lock & ~q_ff.lock};
    nxt_q.irq_stat = (q_ff.irq_stat & ~irq_clr) | irq_set;
    nxt_q.irq = |(nxt_q.irq_stat & nxt_q.irq_mask);
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= '0;
      q_ff.outdiv <= OUTDIV_RST;
      q_ff.ratio <= RATIO_RST;
      q_ff.ctrl_rate <= RATE_RST;
      q_ff.frac_k <= FRAC_K_RST;
      q_ff.int_n <= INT_N_RST;
      q_ff.gain <= GAIN_RST;
      q_ff.refdiv <= REFDIV_RST;
      q_ff.frc_val <= FRC_VAL_RST;
      q_ff.ctrl_word <= CTRL_WORD_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = q_ff.awready;
  assign s_axi_wready = q_ff.wready;
  assign s_axi_bresp = q_ff.bresp;
  assign s_axi_bvalid = q_ff.bvalid;
  assign s_axi_arready = q_ff.arready;
  assign s_axi_rdata = q_ff.rdata;
  assign s_axi_rresp = q_ff.rresp;
  assign s_axi_rvalid = q_ff.rvalid;
  assign loop_clk_out = q_ff.loop_clk;
  assign loop_lock = q_ff.lock;
  assign system_clock_source_select = q_ff.sys_sel;
  assign loop_gpio_out = q_ff.gpio_out;
  assign loop_gpio_oe = q_ff.gpio_oe;
  assign irq = q_ff.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_forced_drive: assert property (q_ff.osc_en && q_ff.frc_sel |=>
    q_ff.acc == 16'($past(q_ff.acc) + {$past(q_ff.frc_val), 10'h000}))
    else $error("forced value not driving oscillator");
  a_forced_reset: assert property ($past(!aresetn) |-> q_ff.frc_val == FRC_VAL_RST && !q_ff.frc_sel)
    else $error("forced value reset wrong");
  a_hold_on_loss: assert property (q_ff.ref_lost |=> $stable(q_ff.ctrl_word))
    else $error("loop word moved without reference");
  a_lock_event: assert property ($rose(q_ff.lock) |-> q_ff.irq_stat[0])
    else $error("lock gain not flagged");
  a_irq_masked: assert property (q_ff.irq_stat[1] && q_ff.irq_mask[1] |-> q_ff.irq)
    else $error("unmasked event without interrupt");
  a_gpio_lock: assert property (q_ff.route[1:0] == ROUTE_LOCK |=> q_ff.gpio_out == $past(q_ff.lock))
    else $error("lock not on gpio");
  a_gpio_clk: assert property (q_ff.route[1:0] == ROUTE_CLK |=> q_ff.gpio_out == $past(q_ff.loop_clk))
    else $error("loop clock not on gpio");
  a_frac_field: assert property ($rose(q_ff.bvalid) && q_ff.aw_idx == IDX_FRAC && q_ff.w_strb == 4'hF
    |-> q_ff.frac_k == q_ff.w_data[15:0])
    else $error("fraction field write wrong");
  a_int_field: assert property ($rose(q_ff.bvalid) && q_ff.aw_idx == IDX_INT && q_ff.w_strb == 4'hF
    |-> q_ff.int_n == q_ff.w_data[14:5])
    else $error("integer field write wrong");
  a_ratio_wrap: assert property (q_ff.ratio == 3'h4 && !q_ff.ref_lost |-> q_ff.pre_cnt <= 5'h0F)
    else $error("ratio prescaler overran");
  a_outdiv_range: assert property (q_ff.outdiv == 6'h07 |-> ##1 q_ff.od_cnt <= 7'h08)
    else $error("output divider overran");
endmodule : flc_freerun_ctrl

// >>> dv/tb.sv
// Self-checking bench for the loop clock control block: registers, forced oscillator, lock, gpio and interrupt
`timescale 1ns/100ps
module tb;
  import flc_pkg::*;
  // Ordinary register cases: optional write, then read back
  typedef struct {logic [11:0] a; bit w; logic [31:0] d; logic [31:0] e; logic [1:0] r;} flc_row_s;
  localparam int TMO = 1024; // Must exceed the 256-cycle reference period, yet keep the run brief
  logic aclk = 0, aresetn = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ref_clk_in = 0, ref_run = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [7:0] ref_cnt = '0;
  wire logic awready, wready, bvalid, arready, rvalid, clk_out, lock, sys_sel, gp_out, gp_oe, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int n_fail = 0, comparisons = 0, n;
  logic [31:0] v;
  logic [1:0] rs;
  flc_row_s rows[22];
  flc_freerun_ctrl #(.REF_TMO_CYC(TMO)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_clk_in(ref_clk_in), .loop_clk_out(clk_out),
    .loop_lock(lock), .system_clock_source_select(sys_sel), .loop_gpio_out(gp_out), .loop_gpio_oe(gp_oe),
    .irq(irq));
  // 100 MHz system clock
  always #5 aclk = ~aclk;
  // Reference pin: period of 256 cycles while running, frozen level when stopped
  always @(posedge aclk) begin
    if (ref_run) begin
      ref_cnt <= ref_cnt + 8'h01;
      ref_clk_in <= ref_cnt[7];
    end
  end
  // Value comparison on four-state data
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Count comparison with a tolerance for phase at the window edges
  task automatic chk_cnt(input string nm, input int e, input int g, input int tol);
    comparisons++;
    if (g < e - tol || g > e + tol) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  // Bus write; both channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
    resp = 2'h1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 0;
        break;
      end
    end
  endtask : wr
  // Bus read; rready held until the answer is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    d = 'x;
    resp = 2'h1;
    for (int i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) begin
        d = rdata;
        resp = rresp;
        rready <= 0;
        break;
      end
    end
  endtask : rd
  // Write that must be accepted
  task automatic wok(input logic [9:0] idx, input logic [31:0] d);
    wr({idx, 2'b00}, d, rs);
    chk("wresp", RESP_OKAY, rs);
  endtask : wok
  // Rising edges of a chosen output over a span of cycles
  task automatic edges(input bit use_gpio, input int cyc, output int cnt);
    logic p;
    cnt = 0;
    p = use_gpio ? gp_out : clk_out;
    repeat (cyc) begin
      @(posedge aclk);
      if ((use_gpio ? gp_out : clk_out) && !p) cnt++;
      p = use_gpio ? gp_out : clk_out;
    end
  endtask : edges
  // Synchronous reset held for two cycles
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
  endtask : do_reset
  // Verdict and end of run
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Watchdog sized well above the expected run of about 11000 cycles
  initial begin
    #(60000 * 10);
    n_fail++;
    summarize();
  end
  initial begin
    rows = '{
      '{{IDX_CTRL, 2'b00}, 0, 0, 32'h0, RESP_OKAY}, '{{IDX_DIV, 2'b00}, 0, 0, 32'h0707, RESP_OKAY},
      '{{IDX_FRAC, 2'b00}, 0, 0, 32'h0, RESP_OKAY}, '{{IDX_INT, 2'b00}, 0, 0, 32'h2EE0, RESP_OKAY},
      '{{IDX_REF, 2'b00}, 0, 0, 32'h0, RESP_OKAY}, '{{IDX_ROUTE, 2'b00}, 0, 0, 32'h0, RESP_OKAY},
      '{{IDX_IRQ_MASK, 2'b00}, 0, 0, 32'h0, RESP_OKAY}, '{{IDX_FRC_SEL, 2'b00}, 0, 0, 32'h0, RESP_OKAY},
      '{{IDX_FRC_VAL, 2'b00}, 0, 0, 32'h19, RESP_OKAY}, '{12'h000, 0, 0, 32'h0, RESP_SLVERR},
      '{{IDX_FRC_VAL, 2'b00}, 1, '1, 32'h3F, RESP_OKAY}, '{{IDX_FRC_VAL, 2'b00}, 1, 0, 32'h0, RESP_OKAY},
      '{{IDX_FRC_SEL, 2'b00}, 1, '1, 32'h1, RESP_OKAY}, '{{IDX_INT, 2'b00}, 1, '1, 32'h7FEF, RESP_OKAY},
      '{{IDX_FRAC, 2'b00}, 1, '1, 32'hFFFF, RESP_OKAY}, '{{IDX_DIV, 2'b00}, 1, '1, 32'h3F77, RESP_OKAY},
      '{{IDX_REF, 2'b00}, 1, '1, 32'h18, RESP_OKAY}, '{{IDX_ROUTE, 2'b00}, 1, '1, 32'h7, RESP_OKAY},
      '{{IDX_IRQ_MASK, 2'b00}, 1, '1, 32'h3, RESP_OKAY}, '{{IDX_CTRL, 2'b00}, 1, '1, 32'h7, RESP_OKAY},
      '{12'h3FC, 1, '1, 32'h0, RESP_SLVERR}, '{{IDX_FRC_VAL, 2'b00}, 1, 32'h2A, 32'h2A, RESP_OKAY}};
    do_reset();
    // Table of reset values, field widths and unmapped places
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d, rs);
        chk("wresp", rows[i].r, rs);
      end
      rd(rows[i].a, v, rs);
      chk("rdata", rows[i].e, v);
      chk("rresp", rows[i].r, rs);
    end
    chk("sysclk_sel", 1'b1, sys_sel);
    chk("gpio_oe", 1'b1, gp_oe);
    // Second reset must restore the forced value
    do_reset();
    rd({IDX_FRC_VAL, 2'b00}, v, rs);
    chk("frc_val_rst", 32'h19, v);
    chk("gpio_oe_rst", 1'b0, gp_oe);
    // Forced oscillator: code 20h ticks every 2 cycles, divider 4 gives a period of 8 cycles
    wok(IDX_FRC_SEL, 32'h1);
    wok(IDX_FRC_VAL, 32'h20);
    wok(IDX_DIV, 32'h0300);
    wok(IDX_ROUTE, 32'h6);
    wok(IDX_CTRL, 32'h1);
    repeat (16) @(posedge aclk);
    edges(1, 2048, n);
    chk_cnt("gpio_clk_edges", 256, n, 1);
    chk("lock_forced", 1'b0, lock);
    rd({IDX_STAT, 2'b00}, v, rs);
    chk("stat_forced", 32'h4, v & 32'h5);
    // Code 10h halves the tick rate; loop clock output counted directly, with system clock selection still off
    wok(IDX_FRC_VAL, 32'h10);
    repeat (16) @(posedge aclk);
    edges(0, 2048, n);
    chk_cnt("clk_edges", 128, n, 1);
    chk("sysclk_sel_off", 1'b0, sys_sel);
    // Referenced lock: word 6400h gives exactly 100 ticks per 256-cycle reference period
    wok(IDX_FRC_SEL, 32'h0);
    wok(IDX_DIV, 32'h0700);
    // N.K = 99.5: ticks per reference period over ratio 1; half rounds the target to 100
    wok(IDX_INT, 32'h0C60);
    wok(IDX_FRAC, 32'h8000);
    wok(IDX_CTRL, 32'h3);
    wok(IDX_IRQ_MASK, 32'h3);
    wok(IDX_ROUTE, 32'h5);
    rd({IDX_IRQ_STAT, 2'b00}, v, rs);
    ref_run <= 1;
    for (int i = 0; i < 12000 && lock !== 1'b1; i++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    chk("lock", 1'b1, lock);
    chk("irq_on_lock", 1'b1, irq);
    chk("gpio_lock", 1'b1, gp_out);
    rd({IDX_IRQ_STAT, 2'b00}, v, rs);
    chk("irq_stat_gain", 32'h1, v & 32'h1);
    rd({IDX_IRQ_STAT, 2'b00}, v, rs);
    chk("irq_stat_clr", 32'h0, v);
    chk("irq_clr", 1'b0, irq);
    // Reference removed: clock and lock must carry on
    ref_run <= 0;
    repeat (4 * TMO) @(posedge aclk);
    rd({IDX_STAT, 2'b00}, v, rs);
    chk("stat_ref_lost", 32'h3, v & 32'h3);
    wok(IDX_ROUTE, 32'h6);
    edges(0, 1024, n);
    chk_cnt("clk_after_ref", 50, n, 2);
    // Forcing the oscillator drops lock and raises the lost event
    wok(IDX_FRC_SEL, 32'h1);
    repeat (4) @(posedge aclk);
    chk("lock_dropped", 1'b0, lock);
    chk("irq_on_loss", 1'b1, irq);
    rd({IDX_IRQ_STAT, 2'b00}, v, rs);
    chk("irq_stat_loss", 32'h2, v & 32'h2);
    summarize();
  end
endmodule : tb
